// File: rtl/pps_supervisor.sv
// Protection supervisor: line qualification, current limit, soft shutdown
`default_nettype none
module pps_supervisor
   import pps_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire pps_flags_s  comp_in,
   output logic             switch_enable,
   output logic             cycle_end,
   output logic             high_line_limit,
   output logic [15:0]      err_level
);
   pps_state_s q;
   pps_state_s n;
   pps_flags_s f;
   pps_flags_s fp;
   logic       ov_cur;
   logic       blanked;
   logic       limit_hit;
   logic       zc_rise;
   logic       peak_rise;
   logic       brown_lo;
   logic [CNT_W-1:0] brown_tc;
   logic       acc;
   logic [31:0] rd;

   assign f  = q.s2;
   assign fp = q.s3;

   always_comb begin
      n = q;
      // ***********************************************
      // Input synchronizers
      // ***********************************************
      n.s1 = comp_in;
      n.s2 = q.s1;
      n.s3 = q.s2;
      zc_rise   = f.zero_cross & ~fp.zero_cross;
      peak_rise = f.half_cycle_peak & ~fp.half_cycle_peak;

      // ***********************************************
      // APB slave, one wait-free access cycle
      // ***********************************************
      acc       = psel & penable;
      n.pready  = psel & ~penable;
      n.pslverr = 1'b0;
      unique case (paddr)
         ADDR_CTRL:       rd = q.regs.ctrl;
         ADDR_STATUS:     rd = {24'h0, q.ov_block, q.therm_fault, q.high_line,
                                q.inrush_mode, q.su_done, q.state};
         ADDR_DEB_TC:     rd = q.regs.deb_tc;
         ADDR_INRUSH_TC:  rd = q.regs.inrush_tc;
         ADDR_STARTUP_TC: rd = q.regs.startup_tc;
         ADDR_LEB_TC:     rd = q.regs.leb_tc;
         ADDR_SOA_ON_TC:  rd = q.regs.soa_on_tc;
         ADDR_SOA_OFF_TC: rd = q.regs.soa_off_tc;
         ADDR_THERM_TC:   rd = q.regs.therm_tc;
         ADDR_SHORT_TC:   rd = q.regs.short_tc;
         ADDR_ERR_LEVEL:  rd = {16'h0, q.err_level};
         default:         rd = 32'h0;
      endcase
      if (psel & ~penable) begin
         n.prdata  = pwrite ? 32'h0 : rd;
         n.pslverr = ~(paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_DEB_TC, ADDR_INRUSH_TC,
                       ADDR_STARTUP_TC, ADDR_LEB_TC, ADDR_SOA_ON_TC, ADDR_SOA_OFF_TC,
                       ADDR_THERM_TC, ADDR_SHORT_TC, ADDR_ERR_LEVEL});
      end
      if (acc & pwrite) begin
         for (int b = 0; b < 4; b++) begin
            if (pstrb[b]) begin
               unique case (paddr)
                  ADDR_CTRL:       n.regs.ctrl[b*8 +: 8]       = pwdata[b*8 +: 8];
                  ADDR_DEB_TC:     n.regs.deb_tc[b*8 +: 8]     = pwdata[b*8 +: 8];
                  ADDR_INRUSH_TC:  n.regs.inrush_tc[b*8 +: 8]  = pwdata[b*8 +: 8];
                  ADDR_STARTUP_TC: n.regs.startup_tc[b*8 +: 8] = pwdata[b*8 +: 8];
                  ADDR_LEB_TC:     n.regs.leb_tc[b*8 +: 8]     = pwdata[b*8 +: 8];
                  ADDR_SOA_ON_TC:  n.regs.soa_on_tc[b*8 +: 8]  = pwdata[b*8 +: 8];
                  ADDR_SOA_OFF_TC: n.regs.soa_off_tc[b*8 +: 8] = pwdata[b*8 +: 8];
                  ADDR_THERM_TC:   n.regs.therm_tc[b*8 +: 8]   = pwdata[b*8 +: 8];
                  ADDR_SHORT_TC:   n.regs.short_tc[b*8 +: 8]   = pwdata[b*8 +: 8];
                  default:         ;
               endcase
            end
         end
      end

      // ***********************************************
      // Line class and current limit selection
      // ***********************************************
      if (!q.regs.ctrl[CTRL_UNIV_BIT]) begin
         n.high_line = 1'b1;
      end else begin
         if (f.line_above_high && (q.regs.ctrl[CTRL_FOLLOW_BIT] || peak_rise))
            n.high_line = 1'b1;
         if (peak_rise) begin
            if (f.line_peak_below_low) begin
               if (q.low_cnt == 2'(LOWLINE_HALF_CYCLES - 1)) begin
                  n.high_line = 1'b0;
                  n.low_cnt   = 2'd0;
               end else begin
                  n.low_cnt = q.low_cnt + 2'd1;
               end
            end else begin
               n.low_cnt = 2'd0;
            end
         end
         // Drop-out timer cleared by any line activity
         if (peak_rise || zc_rise) begin
            n.drop_cnt = '0;
         end else if (q.drop_cnt == CNT_W'(LINE_DROP_CYC - 1)) begin
            n.high_line = 1'b0;
         end else begin
            n.drop_cnt = q.drop_cnt + 1'b1;
         end
      end

      // ***********************************************
      // Cycle-by-cycle limit, blanking, safe area
      // ***********************************************
      n.cycle_end = 1'b0;
      n.on_cnt    = f.switch_on ? ((q.on_cnt == '1) ? q.on_cnt : q.on_cnt + 1'b1) : '0;
      blanked     = q.on_cnt < q.regs.leb_tc;
      limit_hit   = f.switch_on & f.current_at_limit & ~blanked;
      if (limit_hit) begin
         n.cycle_end = 1'b1;
         if (q.on_cnt < q.regs.soa_on_tc) begin
            n.soa_cnt = q.regs.soa_off_tc;
            n.err_level = (q.err_level > ERR_HALF) ? q.err_level - ERR_HALF : ERR_RST;
         end
      end else if (q.soa_cnt != '0) begin
         n.soa_cnt = q.soa_cnt - 1'b1;
      end

      // Overvoltage block with feedback hysteresis
      if (f.output_overvoltage_trip)
         n.ov_block = 1'b1;
      else if (f.fb_below_ov_hyst)
         n.ov_block = 1'b0;

      // Thermal fault latch: trip wins, clears only when cooled
      if (f.die_over_temp)
         n.therm_fault = 1'b1;
      else if (f.die_cooled)
         n.therm_fault = 1'b0;

      // ***********************************************
      // Sequencer
      // ***********************************************
      brown_lo = q.inrush_mode ? ~f.line_above_inrush :
                 f.square_wave ? ~f.line_above_square :
                                 ~f.line_above_brown_out;
      brown_tc = q.inrush_mode ? q.regs.inrush_tc : q.regs.deb_tc;
      if (zc_rise) n.missed_half = 1'b0;
      unique case (q.state)
         PPS_OFF: begin
            n.err_level = ERR_RST;
            if (f.bias_above_release) n.state = PPS_CHECK;
         end
         PPS_CHECK: begin
            if (f.pin_fault_ok && !q.therm_fault && !f.fb_comp_short_suspect)
               n.state = PPS_WAIT_BROWN_IN;
         end
         PPS_WAIT_BROWN_IN: begin
            if (f.line_above_brown_in && !f.line_peak_over_400) begin
               n.state       = PPS_RUN;
               n.inrush_mode = 1'b1;
               n.su_cnt      = '0;
               n.su_done     = 1'b0;
               n.deb_cnt     = '0;
               n.short_cnt   = '0;
               n.err_level   = ERR_MAX;
            end
         end
         PPS_RUN: begin
            // A safe-area pull-down in this cycle must not be undone here
            if (q.err_level != ERR_MAX && q.soa_cnt == '0 && !limit_hit)
               n.err_level = q.err_level + 16'h0001;
            if (!q.su_done) begin
               if (q.su_cnt >= q.regs.startup_tc) n.su_done = 1'b1;
               else n.su_cnt = q.su_cnt + 1'b1;
            end
            if (q.su_done && q.inrush_mode && f.line_above_inrush) begin
               n.inrush_mode = 1'b0;
               n.deb_cnt     = '0;
            end
            if (brown_lo && !(zc_rise && !q.missed_half)) begin
               // Every crossing cycle is left out of the count, since missed_half is never set
               if (zc_rise) n.missed_half = 1'b1;
               if (q.deb_cnt >= brown_tc) n.state = PPS_WAIT_ZC;
               else n.deb_cnt = q.deb_cnt + 1'b1;
            end else if (!brown_lo) begin
               if (q.inrush_mode && q.deb_cnt != '0) begin
                  n.su_cnt = '0;
                  n.su_done = 1'b0;
               end
               n.deb_cnt = '0;
            end
            if (q.short_cnt >= q.regs.short_tc) n.state = PPS_LATCHED;
            else if (f.fb_comp_short_suspect) n.short_cnt = q.short_cnt + 1'b1;
            else n.short_cnt = '0;
            if (q.therm_fault) begin
               n.state     = PPS_WAIT_ZC;
               n.therm_cnt = '0;
            end
            if (!f.bias_above_trip) n.state = PPS_OFF;
         end
         PPS_WAIT_ZC: begin
            // Thermal delay bounds the ramp after a crossing; nothing bounds this wait
            if (q.therm_fault && q.therm_cnt != '0) n.therm_cnt = q.therm_cnt + 1'b1;
            if (zc_rise) begin
               n.state    = PPS_RAMP;
               n.ramp_cnt = '0;
               if (q.therm_fault) n.state = PPS_RAMP;
            end
         end
         PPS_RAMP: begin
            n.ramp_cnt  = q.ramp_cnt + 1'b1;
            // Wide product: a 32-bit one wraps long before the ramp ends
            n.err_level = 16'(48'(ERR_MAX) - (48'(q.ramp_cnt) + 48'd1) * 48'(ERR_MAX)
                              / 48'(SOFT_SHUT_CYC));
            if (q.therm_fault && q.ramp_cnt >= q.regs.therm_tc) n.err_level = ERR_RST;
            if (n.err_level == ERR_RST || q.ramp_cnt == CNT_W'(SOFT_SHUT_CYC - 1)) begin
               n.err_level = ERR_RST;
               n.state     = q.therm_fault ? PPS_LATCHED : PPS_CHECK;
            end
         end
         PPS_LATCHED: begin
            n.err_level = ERR_RST;
            if (!q.therm_fault && f.die_cooled) n.state = PPS_CHECK;
         end
      endcase
      if (q.state != PPS_RUN && q.state != PPS_WAIT_ZC && q.state != PPS_RAMP &&
          q.state != PPS_LATCHED)
         n.inrush_mode = 1'b0;
      if (!f.bias_above_trip && q.state != PPS_OFF) n.state = PPS_OFF;
      ov_cur = n.ov_block;
      n.switch_enable = ((n.state == PPS_RUN) || (n.state == PPS_WAIT_ZC) ||
                         (n.state == PPS_RAMP)) && !ov_cur && (n.soa_cnt == '0);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q                 <= '0;
         q.state           <= PPS_OFF;
         q.regs.ctrl       <= CTRL_RST;
         q.regs.deb_tc     <= DEB_TC_RST;
         q.regs.inrush_tc  <= INRUSH_TC_RST;
         q.regs.startup_tc <= STARTUP_TC_RST;
         q.regs.leb_tc     <= LEB_TC_RST;
         q.regs.soa_on_tc  <= SOA_ON_TC_RST;
         q.regs.soa_off_tc <= SOA_OFF_TC_RST;
         q.regs.therm_tc   <= THERM_TC_RST;
         q.regs.short_tc   <= SHORT_TC_RST;
      end else begin
         q <= n;
      end
   end

   assign pready          = q.pready;
   assign prdata          = q.prdata;
   assign pslverr         = q.pslverr;
   assign switch_enable   = q.switch_enable;
   assign cycle_end       = q.cycle_end;
   assign high_line_limit = q.high_line;
   assign err_level       = q.err_level;

   // ***********************************************
   // Checks
   // ***********************************************
   AST_NO_START_HIGH_PEAK: assert property (@(posedge pclk) disable iff (!presetn)
      (q.state == PPS_WAIT_BROWN_IN && f.line_peak_over_400)
      |=> q.state != PPS_RUN)
      else $error("start with peak over limit");
   AST_RAMP_ON_ZC: assert property (@(posedge pclk) disable iff (!presetn)
      (q.state == PPS_WAIT_ZC && !zc_rise && f.bias_above_trip)
      |=> q.state == PPS_WAIT_ZC)
      else $error("ramp began before zero crossing");
   AST_RAMP_START: assert property (@(posedge pclk) disable iff (!presetn)
      (q.state == PPS_WAIT_ZC && zc_rise && f.bias_above_trip)
      |=> q.state == PPS_RAMP)
      else $error("ramp did not start at zero crossing");
   AST_CYCLE_END: assert property (@(posedge pclk) disable iff (!presetn)
      limit_hit
      |=> cycle_end)
      else $error("limit did not end cycle");
   AST_BLANK: assert property (@(posedge pclk) disable iff (!presetn)
      (f.switch_on && q.on_cnt < q.regs.leb_tc)
      |=> !cycle_end)
      else $error("cycle ended inside blanking");
   AST_FIXED_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
      !q.regs.ctrl[CTRL_UNIV_BIT]
      |=> high_line_limit)
      else $error("high-line part left fixed limit");
   AST_OV_STOP: assert property (@(posedge pclk) disable iff (!presetn)
      f.output_overvoltage_trip
      |=> !switch_enable)
      else $error("switching during overvoltage");
   AST_BIAS_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
      !f.bias_above_trip
      |=> q.state == PPS_OFF)
      else $error("running below bias trip");
   AST_OFF_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      (q.state == PPS_OFF && !f.bias_above_release)
      |=> q.state == PPS_OFF)
      else $error("left lock-out below release level");
   AST_CHECK_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      (q.state == PPS_CHECK && f.fb_comp_short_suspect && f.bias_above_trip)
      |=> q.state == PPS_CHECK)
      else $error("start checks passed with a fault");
   AST_SOA_HALF: assert property (@(posedge pclk) disable iff (!presetn)
      (limit_hit && q.on_cnt < q.regs.soa_on_tc && q.state == PPS_RUN)
      |=> !switch_enable)
      else $error("safe area off-time not forced");
   AST_SOA_ERR: assert property (@(posedge pclk) disable iff (!presetn)
      (limit_hit && q.on_cnt < q.regs.soa_on_tc && q.state == PPS_RUN)
      |=> err_level < ERR_HALF)
      else $error("error level not pulled down");
   AST_SHORT_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
      (q.state == PPS_RUN && q.short_cnt >= q.regs.short_tc && !q.therm_fault
       && f.bias_above_trip)
      |=> q.state == PPS_LATCHED)
      else $error("confirmed short not shut down");
   AST_THERM_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      (q.therm_fault && q.state == PPS_RUN && f.bias_above_trip)
      |=> q.state == PPS_WAIT_ZC)
      else $error("thermal fault not acted on");
   AST_THERM_END: assert property (@(posedge pclk) disable iff (!presetn)
      (q.state == PPS_RAMP && q.therm_fault && q.ramp_cnt >= q.regs.therm_tc
       && f.bias_above_trip)
      |=> q.state == PPS_LATCHED && err_level == ERR_RST)
      else $error("thermal ramp overran its delay");
   COV_RUN: cover property (@(posedge pclk) q.state == PPS_WAIT_BROWN_IN ##1 q.state == PPS_RUN);
   COV_RAMP: cover property (@(posedge pclk) q.state == PPS_RAMP ##1 q.state == PPS_CHECK);
   COV_SOA: cover property (@(posedge pclk) limit_hit && q.on_cnt < q.regs.soa_on_tc);
   COV_LATCH: cover property (@(posedge pclk) q.state == PPS_RAMP ##1 q.state == PPS_LATCHED);
   COV_HIGH_LINE: cover property (@(posedge pclk) !q.high_line ##1 q.high_line);
endmodule
`default_nettype wire

// File: rtl/pps_pkg.sv
// Package: constants and carrier types of the protection supervisor
`default_nettype none
package pps_pkg;
   // ***********************************************
   // Timing, 125 MHz clock
   // ***********************************************
   localparam int unsigned CLK_MHZ               = 125;
   localparam int unsigned SOFT_SHUT_US          = 1000;
   localparam int unsigned SOFT_SHUT_CYC         = SOFT_SHUT_US * CLK_MHZ;
   localparam int unsigned LINE_DROP_MS          = 37;
   localparam int unsigned LINE_DROP_CYC         = LINE_DROP_MS * 1000 * CLK_MHZ;
   localparam int unsigned LOWLINE_HALF_CYCLES   = 3;
   localparam int unsigned HIGHLINE_HALF_CYCLES  = 1;
   localparam int unsigned CNT_W                 = 32;
   localparam logic [15:0] ERR_MAX               = 16'hffff;
   localparam logic [15:0] ERR_HALF              = 16'h8000;
   localparam logic [15:0] ERR_RST               = 16'h0000;

   // ***********************************************
   // APB register map
   // ***********************************************
   localparam logic [7:0] ADDR_CTRL       = 8'h00;
   localparam logic [7:0] ADDR_STATUS     = 8'h04;
   localparam logic [7:0] ADDR_DEB_TC     = 8'h08;
   localparam logic [7:0] ADDR_INRUSH_TC  = 8'h0c;
   localparam logic [7:0] ADDR_STARTUP_TC = 8'h10;
   localparam logic [7:0] ADDR_LEB_TC     = 8'h14;
   localparam logic [7:0] ADDR_SOA_ON_TC  = 8'h18;
   localparam logic [7:0] ADDR_SOA_OFF_TC = 8'h1c;
   localparam logic [7:0] ADDR_THERM_TC   = 8'h20;
   localparam logic [7:0] ADDR_SHORT_TC   = 8'h24;
   localparam logic [7:0] ADDR_ERR_LEVEL  = 8'h28;
   localparam int unsigned CTRL_UNIV_BIT   = 0;
   localparam int unsigned CTRL_FOLLOW_BIT = 1;
   localparam logic [31:0] CTRL_RST       = 32'h0000_0003;
   localparam logic [31:0] DEB_TC_RST     = 32'h0000_1000;
   localparam logic [31:0] INRUSH_TC_RST  = 32'h0000_2000;
   localparam logic [31:0] STARTUP_TC_RST = 32'h0000_4000;
   localparam logic [31:0] LEB_TC_RST     = 32'h0000_0020;
   localparam logic [31:0] SOA_ON_TC_RST  = 32'h0000_0040;
   localparam logic [31:0] SOA_OFF_TC_RST = 32'h0000_0100;
   localparam logic [31:0] THERM_TC_RST   = 32'h0000_0800;
   localparam logic [31:0] SHORT_TC_RST   = 32'h0000_0010;

   typedef enum logic [2:0] {
      PPS_OFF, PPS_CHECK, PPS_WAIT_BROWN_IN, PPS_RUN, PPS_WAIT_ZC, PPS_RAMP, PPS_LATCHED
   } pps_state_e;

   // Synchronized comparator flags
   typedef struct packed {
      logic bias_above_release;  // bias_lockout_release_level
      logic bias_above_trip;     // above bias_lockout_trip_level
      logic line_above_brown_in;
      logic line_above_brown_out;
      logic line_above_inrush;
      logic line_above_square;
      logic line_peak_over_400;
      logic line_above_high;
      logic line_peak_below_low;
      logic half_cycle_peak;     // Peak detector strobe (level)
      logic zero_cross;
      logic square_wave;
      logic switch_on;
      logic current_at_limit;
      logic output_overvoltage_trip;
      logic fb_below_ov_hyst;
      logic fb_comp_short_suspect;
      logic die_over_temp;
      logic die_cooled;
      logic pin_fault_ok;
   } pps_flags_s;

   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] deb_tc;
      logic [31:0] inrush_tc;
      logic [31:0] startup_tc;
      logic [31:0] leb_tc;
      logic [31:0] soa_on_tc;
      logic [31:0] soa_off_tc;
      logic [31:0] therm_tc;
      logic [31:0] short_tc;
   } pps_regs_s;

   typedef struct packed {
      pps_flags_s       s1;
      pps_flags_s       s2;
      pps_flags_s       s3;
      pps_regs_s        regs;
      pps_state_e       state;
      logic [CNT_W-1:0] deb_cnt;
      logic [CNT_W-1:0] su_cnt;
      logic             su_done;
      logic             inrush_mode;
      logic [CNT_W-1:0] ramp_cnt;
      logic [CNT_W-1:0] therm_cnt;
      logic             therm_fault;
      logic [1:0]       low_cnt;
      logic             high_line;
      logic [CNT_W-1:0] drop_cnt;
      logic [CNT_W-1:0] on_cnt;
      logic [CNT_W-1:0] soa_cnt;
      logic             ov_block;
      logic [CNT_W-1:0] short_cnt;
      logic             missed_half;
      logic [15:0]      err_level;
      logic             switch_enable;
      logic             cycle_end;
      logic             pready;
      logic [31:0]      prdata;
      logic             pslverr;
   } pps_state_s;
endpackage
`default_nettype wire

// File: test/pps_stage_model.sv
// Boost stage and line sensing model that drives the comparator flags
`default_nettype none
module pps_stage_model
   import pps_pkg::*;
#(
   parameter int HALF = 40
)
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire pps_flags_s lvl,
   input  wire logic [7:0] lim_at,
   input  wire logic       switch_enable,
   input  wire logic       cycle_end,
   output pps_flags_s      comp
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ph_ff;
   logic [7:0] on_ff;
   logic       sw_ff;
   // ***************************************
   // Switch and line phase
   // ***************************************
   // Switch opens on cycle end or at a fixed maximum on-time, then recloses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph_ff <= 8'h00;
         on_ff <= 8'h00;
         sw_ff <= 1'b0;
      end else begin
         ph_ff <= (ph_ff == 8'(HALF - 1)) ? 8'h00 : ph_ff + 8'h01;
         sw_ff <= switch_enable && !cycle_end && on_ff != 8'h3f;
         on_ff <= (sw_ff && switch_enable && !cycle_end && on_ff != 8'h3f) ? on_ff + 8'h01 : 8'h00;
      end
   end
   // Without line there are no crossings or peaks
   always_comb begin
      comp                  = lvl;
      comp.zero_cross       = lvl.line_above_brown_out && ph_ff < 8'h04;
      comp.half_cycle_peak  = lvl.line_above_brown_out && ph_ff >= 8'(HALF / 2)
                              && ph_ff < 8'(HALF / 2 + 4);
      comp.switch_on        = sw_ff;
      comp.current_at_limit = sw_ff && on_ff == lim_at;
   end
endmodule
`default_nettype wire

// File: test/pps_supervisor_bench.sv
// Self-checking bench of the protection supervisor
`default_nettype none
module pps_supervisor_bench
   import pps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] rst;
      logic [31:0] wr;
      logic [31:0] rb;
      logic        err;
   } pps_row_s;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic        switch_enable, cycle_end, high_line_limit;
   logic [7:0]  paddr, lim_at;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] err_level;
   pps_flags_s  lvl, comp;
   pps_row_s    rows [11];
   int          n_fail, cmp_count;
   always #4 pclk = ~pclk;
   pps_supervisor dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .comp_in(comp), .switch_enable(switch_enable),
      .cycle_end(cycle_end), .high_line_limit(high_line_limit), .err_level(err_level));
   pps_stage_model #(.HALF(40)) model (.pclk(pclk), .presetn(presetn), .lvl(lvl),
      .lim_at(lim_at), .switch_enable(switch_enable), .cycle_end(cycle_end), .comp(comp));
   // ***************************************
   // Tasks
   // ***************************************
   task automatic test_done();
      $display("Compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic bad(input string m);
      n_fail++;
      $display("Error at %0t: %s", $time, m);
   endtask
   task automatic chk32(input logic [31:0] g, input logic [31:0] e, input string m);
      cmp_count++;
      if (g !== e) bad($sformatf("%s got %h exp %h", m, g, e));
   endtask
   function automatic logic pick(input int s);
      return (s == 0) ? switch_enable : (s == 1) ? high_line_limit : cycle_end;
   endfunction
   task automatic wait_for(input int s, input logic v, input int lim);
      int n = 0;
      cmp_count++;
      while (pick(s) !== v && n < lim) begin
         @(posedge pclk);
         n++;
      end
      if (pick(s) !== v) begin
         bad($sformatf("output %0d never reached %b", s, v));
         test_done();
      end
   endtask
   task automatic hold(input int s, input logic v, input int cyc);
      int k;
      cmp_count++;
      for (k = 0; k < cyc; k++) begin
         @(posedge pclk);
         if (pick(s) !== v) begin
            bad($sformatf("output %0d left %b", s, v));
            break;
         end
      end
   endtask
   // Peaks pace the half-cycle counts, so stimulus starts right after one
   task automatic after_peak();
      int n = 0;
      while (comp.half_cycle_peak !== 1'b1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      while (comp.half_cycle_peak === 1'b1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 100) begin
         bad("no line peak");
         test_done();
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         bad("no bus answer");
         test_done();
      end
   endtask
   // ***************************************
   // Sequence
   // ***************************************
   initial begin
      rows = '{'{ADDR_CTRL, CTRL_RST, 32'h3, 32'h3, 1'b0},
         '{ADDR_DEB_TC, DEB_TC_RST, 32'h10, 32'h10, 1'b0},
         '{ADDR_INRUSH_TC, INRUSH_TC_RST, 32'h20, 32'h20, 1'b0},
         '{ADDR_STARTUP_TC, STARTUP_TC_RST, 32'h30, 32'h30, 1'b0},
         '{ADDR_LEB_TC, LEB_TC_RST, 32'h4, 32'h4, 1'b0},
         '{ADDR_SOA_ON_TC, SOA_ON_TC_RST, 32'h8, 32'h8, 1'b0},
         '{ADDR_SOA_OFF_TC, SOA_OFF_TC_RST, 32'h10, 32'h10, 1'b0},
         '{ADDR_THERM_TC, THERM_TC_RST, 32'h40, 32'h40, 1'b0},
         '{ADDR_SHORT_TC, SHORT_TC_RST, 32'h6, 32'h6, 1'b0},
         '{ADDR_ERR_LEVEL, 32'h0, 32'hffff_ffff, 32'h0, 1'b0},
         '{8'h2c, 32'h0, 32'hffff_ffff, 32'h0, 1'b1}};
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata, n_fail, cmp_count} = '0;
      lim_at = 8'hff;
      lvl = '0;
      {lvl.line_above_brown_in, lvl.line_above_brown_out, lvl.line_above_inrush} = 3'h7;
      {lvl.line_above_square, lvl.line_peak_below_low, lvl.pin_fault_ok} = 3'h7;
      {lvl.fb_below_ov_hyst, lvl.die_cooled} = 2'h3;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         apb(1'b0, rows[i].a, 32'h0);
         chk32(rd, rows[i].rst, "reset value");
         chk32(32'(er), 32'(rows[i].err), "read error");
         apb(1'b1, rows[i].a, rows[i].wr);
         apb(1'b0, rows[i].a, 32'h0);
         chk32(rd, rows[i].rb, "read back");
      end
      hold(0, 1'b0, 100);
      {lvl.bias_above_release, lvl.bias_above_trip, lvl.line_peak_over_400} <= 3'h7;
      hold(0, 1'b0, 100);
      lvl.line_peak_over_400 <= 1'b0;
      wait_for(0, 1'b1, 2000);
      lim_at <= 8'h01;
      hold(2, 1'b0, 200);
      lim_at <= 8'h0c;
      wait_for(2, 1'b1, 100);
      lim_at <= 8'h06;
      wait_for(0, 1'b0, 100);
      chk32(32'(err_level), 32'(ERR_MAX - ERR_HALF), "safe area pull-down");
      wait_for(0, 1'b1, 40);
      // Second hit starts below the maximum level
      wait_for(0, 1'b0, 60);
      chk32(32'(err_level[15:8]), 32'h0, "second pull-down");
      lim_at <= 8'hff;
      wait_for(0, 1'b1, 40);
      after_peak();
      {lvl.line_above_high, lvl.line_peak_below_low} <= 2'h2;
      wait_for(1, 1'b1, 12);
      after_peak();
      {lvl.line_above_high, lvl.line_peak_below_low} <= 2'h1;
      hold(1, 1'b1, 90);
      wait_for(1, 1'b0, 50);
      {lvl.output_overvoltage_trip, lvl.fb_below_ov_hyst} <= 2'h2;
      wait_for(0, 1'b0, 10);
      lvl.output_overvoltage_trip <= 1'b0;
      hold(0, 1'b0, 50);
      lvl.fb_below_ov_hyst <= 1'b1;
      wait_for(0, 1'b1, 50);
      {lvl.die_over_temp, lvl.die_cooled} <= 2'h2;
      wait_for(0, 1'b0, 130);
      lvl.die_over_temp <= 1'b0;
      hold(0, 1'b0, 100);
      chk32(32'(err_level), 32'h0, "error level");
      lvl.die_cooled <= 1'b1;
      wait_for(0, 1'b1, 2000);
      {lvl.bias_above_release, lvl.bias_above_trip} <= 2'h0;
      wait_for(0, 1'b0, 20);
      {lvl.bias_above_release, lvl.bias_above_trip} <= 2'h3;
      wait_for(0, 1'b1, 2000);
      lvl.fb_comp_short_suspect <= 1'b1;
      wait_for(0, 1'b0, 40);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk32(rd, CTRL_RST, "ctrl after reset");
      chk32(32'(switch_enable), 32'h0, "enable after reset");
      chk32(32'(high_line_limit), 32'h0, "low-line after reset");
      apb(1'b1, ADDR_CTRL, 32'h0);
      wait_for(1, 1'b1, 10);
      test_done();
   end
endmodule
`default_nettype wire
